// ### design/wiwdt_pkg.sv
package wiwdt_pkg;
  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] KEY_ENTRY_OFS = 8'h00;
  localparam logic [7:0] CONTROL_SETTINGS_OFS = 8'h04;
  localparam logic [7:0] RELOAD_VALUE_OFS = 8'h08;
  localparam logic [7:0] STATUS_FLAGS_OFS = 8'h0c;
  localparam logic [7:0] WINDOW_VALUE_OFS = 8'h10;
  localparam logic [7:0] COUNTER_VALUE_OFS = 8'h24;
  // ****************************************
  // Key values
  // ****************************************
  localparam logic [15:0] KEY_START = 16'hcccc;
  localparam logic [15:0] KEY_REFRESH = 16'haaaa;
  localparam logic [15:0] KEY_UNLOCK = 16'h5555;
  localparam logic [15:0] KEY_STOP1 = 16'h5a5a;
  localparam logic [15:0] KEY_STOP2 = 16'ha5a5;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int CTL_PAUSE_BIT = 5;
  localparam int CTL_IE_BIT = 4;
  localparam int CTL_ACTION_BIT = 3;
  localparam int ST_RELOAD_BIT = 5;
  localparam int ST_RUN_BIT = 4;
  localparam int ST_WRAP_BIT = 3;
  localparam int ST_WIN_UPD_BIT = 2;
  localparam int ST_RLD_UPD_BIT = 1;
  localparam int ST_CTL_UPD_BIT = 0;
  // ****************************************
  // Reset values and counts
  // ****************************************
  localparam logic [11:0] CNT_START_VAL = 12'hfff;
  localparam logic [11:0] RELOAD_RST = 12'hfff;
  localparam logic [11:0] WINDOW_RST = 12'hfff;
  localparam logic [9:0] PRESCALE_BASE = 10'h004;
  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic pause;
    logic irq_enable_bit;
    logic action;
    logic [2:0] prescale_sel;
  } wiwdt_ctl_t;
  localparam wiwdt_ctl_t CTL_RST = '{1'b0, 1'b0, 1'b0, 3'h0};
endpackage

// ### design/wiwdt_top.sv
`timescale 1ns/1ps
// Overview of operation
// - Start key begins countdown from 0xfff.
// - Refresh key loads the reload value into the counter.
// - At zero an overflow event occurs and the counter reloads.
// - Action 0 resets; action 1 interrupts only if enabled.
// - Pause bit 1 halts counting in deep sleep, resuming after.
// - Window active only when window below reload; resets to 0xfff.
// - A window register change also reloads the counter.
// - Refresh while counter above window requests a system reset.
// - Unlock key opens protected registers; other keys lock them.
// - Protected registers are locked after reset.
// - Stop only after the two stop keys are written back to back.
// - Start, refresh and stop keys relock protected registers.
// - Status shows running bit 4, overflow bit 3, reloading bit 5.
// - Status bits 2,1,0 show pending window, reload, control updates.
// - Prescale divides the slow clock by four times two to the field.
// - Period is reload value plus one prescaled ticks.
// - Protected registers accept writes only while running.
// - Counter is 12-bit, ticking from the low speed oscillator.
// - Overflow flag stays set until software writes zero to it.
module wiwdt_top #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_RST_B,
  // APB slave
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [ADDR_W-1:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  // Low speed oscillator and sleep state
  input wire logic I_LSO_CLK,
  input wire logic I_DEEP_SLEEP,
  // Watchdog actions
  output logic O_SYS_RST_REQ,
  output logic O_WDT_IRQ
);
  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [2:0] lso_sync_r;
  logic [2:0] slp_sync_r;
  logic lso_lvl_r;
  logic slp_lvl_r;
  logic lso_edge;
  logic lso_agree;
  logic slp_agree;
  assign lso_agree = lso_sync_r[1] == lso_sync_r[2];
  assign slp_agree = slp_sync_r[1] == slp_sync_r[2];
  // Three stage capture of the pins
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      lso_sync_r <= 3'h0;
      slp_sync_r <= 3'h0;
    end else begin
      lso_sync_r <= {lso_sync_r[1:0], I_LSO_CLK};
      slp_sync_r <= {slp_sync_r[1:0], I_DEEP_SLEEP};
    end
  end

  // Filtered levels follow once stages agree
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      lso_lvl_r <= 1'b0;
    end else if (lso_agree) begin
      lso_lvl_r <= lso_sync_r[2];
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      slp_lvl_r <= 1'b0;
    end else if (slp_agree) begin
      slp_lvl_r <= slp_sync_r[2];
    end
  end
  assign lso_edge = lso_agree && lso_sync_r[2] && !lso_lvl_r;

  // ****************************************
  // Bus decode
  // ****************************************
  logic [7:0] ofs;
  logic setup_ph;
  logic access_ph;
  logic wr;
  logic hit_key;
  logic hit_ctl;
  logic hit_rld;
  logic hit_st;
  logic hit_win;
  logic hit_cnt;
  logic mapped;
  logic [15:0] key;
  assign ofs = 8'(I_PADDR);
  assign setup_ph = I_PSEL && !I_PENABLE;
  assign access_ph = I_PSEL && I_PENABLE;
  assign wr = access_ph && I_PWRITE;
  assign hit_key = ofs == wiwdt_pkg::KEY_ENTRY_OFS;
  assign hit_ctl = ofs == wiwdt_pkg::CONTROL_SETTINGS_OFS;
  assign hit_rld = ofs == wiwdt_pkg::RELOAD_VALUE_OFS;
  assign hit_st = ofs == wiwdt_pkg::STATUS_FLAGS_OFS;
  assign hit_win = ofs == wiwdt_pkg::WINDOW_VALUE_OFS;
  assign hit_cnt = ofs == wiwdt_pkg::COUNTER_VALUE_OFS;
  assign mapped = hit_key || hit_ctl || hit_rld || hit_st || hit_win
    || hit_cnt;
  assign key = I_PWDATA[15:0];
  assign O_PREADY = 1'b1;
  assign O_PSLVERR = access_ph && !mapped;

  // ****************************************
  // State registers
  // ****************************************
  logic run_r;
  logic unlock_r;
  logic stop1_r;
  logic wrap_r;
  logic reload_pend_r;
  logic ctl_upd_r;
  logic rld_upd_r;
  logic win_upd_r;
  logic rst_req_r;
  logic irq_r;
  wiwdt_pkg::wiwdt_ctl_t ctl_sh_r;
  wiwdt_pkg::wiwdt_ctl_t ctl_r;
  logic [11:0] rld_sh_r;
  logic [11:0] rld_r;
  logic [11:0] win_sh_r;
  logic [11:0] win_r;
  logic [11:0] cnt_r;
  logic [8:0] pre_r;
  logic [31:0] rdata_r;

  // ****************************************
  // Key and write qualification
  // ****************************************
  logic key_wr;
  logic k_start;
  logic k_refresh;
  logic k_stop;
  logic prot_ok;
  logic ctl_wr;
  logic rld_wr;
  logic win_wr;
  logic win_mode;
  logic early;
  logic wrap_clr;
  assign key_wr = wr && hit_key;
  assign k_start = key_wr && key == wiwdt_pkg::KEY_START;
  assign k_refresh = key_wr && key == wiwdt_pkg::KEY_REFRESH;
  assign k_stop = key_wr && stop1_r && key == wiwdt_pkg::KEY_STOP2;
  assign prot_ok = unlock_r && run_r;
  assign ctl_wr = wr && hit_ctl && prot_ok && !ctl_upd_r;
  assign rld_wr = wr && hit_rld && prot_ok && !rld_upd_r;
  assign win_wr = wr && hit_win && prot_ok && !win_upd_r;
  assign win_mode = win_r < rld_r;
  assign early = k_refresh && run_r && win_mode && cnt_r > win_r;
  assign wrap_clr = wr && hit_st && !I_PWDATA[wiwdt_pkg::ST_WRAP_BIT];

  // ****************************************
  // Counting path
  // ****************************************
  logic halted;
  logic [8:0] pre_lim;
  logic tick;
  logic wrap;
  logic win_chg;
  logic start_ev;
  logic load_ev;
  logic pre_clr;
  logic pre_inc;
  logic run_nxt;
  logic [11:0] cnt_nxt;
  logic [8:0] pre_nxt;
  logic pend_nxt;
  assign halted = ctl_r.pause && slp_lvl_r;
  assign pre_lim = 9'((wiwdt_pkg::PRESCALE_BASE << ctl_r.prescale_sel)
    - 10'h001);
  assign tick = lso_edge && run_r && !halted && pre_r == pre_lim;
  assign wrap = tick && cnt_r == 12'h000;
  assign win_chg = lso_edge && win_upd_r && win_sh_r != win_r;
  assign start_ev = k_start && !run_r;
  assign load_ev = lso_edge && (reload_pend_r || win_chg);
  assign run_nxt = start_ev ? 1'b1 : k_stop ? 1'b0 : run_r;
  assign cnt_nxt = start_ev ? wiwdt_pkg::CNT_START_VAL :
    k_stop ? cnt_r :
    (load_ev || wrap) ? rld_r :
    tick ? cnt_r - 12'h001 : cnt_r;
  assign pre_clr = start_ev || (!k_stop && (load_ev || wrap || tick));
  assign pre_inc = !k_stop && lso_edge && run_r && !halted;
  assign pre_nxt = pre_clr ? 9'h000 : pre_inc ? pre_r + 9'h001 : pre_r;
  assign pend_nxt = (k_refresh && run_r) ? 1'b1 :
    lso_edge ? 1'b0 : reload_pend_r;

  // ****************************************
  // Counter registers
  // ****************************************
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      run_r <= 1'b0;
    end else begin
      run_r <= run_nxt;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      cnt_r <= wiwdt_pkg::CNT_START_VAL;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      pre_r <= 9'h000;
    end else begin
      pre_r <= pre_nxt;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      reload_pend_r <= 1'b0;
    end else begin
      reload_pend_r <= pend_nxt;
    end
  end

  // ****************************************
  // Key unlock and stop sequence state
  // ****************************************
  logic unlock_nxt;
  logic stop1_nxt;
  assign unlock_nxt = key_wr ? key == wiwdt_pkg::KEY_UNLOCK : unlock_r;
  assign stop1_nxt = key_wr ? key == wiwdt_pkg::KEY_STOP1 : stop1_r;
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      unlock_r <= 1'b0;
      stop1_r <= 1'b0;
    end else begin
      unlock_r <= unlock_nxt;
      stop1_r <= stop1_nxt;
    end
  end

  // ****************************************
  // Protected registers
  // ****************************************
  // Pending update flags
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      ctl_sh_r <= wiwdt_pkg::CTL_RST;
      ctl_r <= wiwdt_pkg::CTL_RST;
      ctl_upd_r <= 1'b0;
    end else if (ctl_wr) begin
      ctl_sh_r <= wiwdt_pkg::wiwdt_ctl_t'(I_PWDATA[5:0]);
      ctl_upd_r <= 1'b1;
    end else if (lso_edge && ctl_upd_r) begin
      ctl_r <= ctl_sh_r;
      ctl_upd_r <= 1'b0;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      rld_sh_r <= wiwdt_pkg::RELOAD_RST;
      rld_r <= wiwdt_pkg::RELOAD_RST;
      rld_upd_r <= 1'b0;
    end else if (rld_wr) begin
      rld_sh_r <= I_PWDATA[11:0];
      rld_upd_r <= 1'b1;
    end else if (lso_edge && rld_upd_r) begin
      rld_r <= rld_sh_r;
      rld_upd_r <= 1'b0;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      win_sh_r <= wiwdt_pkg::WINDOW_RST;
      win_r <= wiwdt_pkg::WINDOW_RST;
      win_upd_r <= 1'b0;
    end else if (win_wr) begin
      win_sh_r <= I_PWDATA[11:0];
      win_upd_r <= 1'b1;
    end else if (lso_edge && win_upd_r) begin
      win_r <= win_sh_r;
      win_upd_r <= 1'b0;
    end
  end

  // ****************************************
  // Overflow actions
  // ****************************************
  logic wrap_nxt;
  logic rst_req_nxt;
  logic irq_nxt;
  assign wrap_nxt = wrap ? 1'b1 : wrap_clr ? 1'b0 : wrap_r;
  assign rst_req_nxt = (wrap && !ctl_r.action) || early;
  assign irq_nxt = wrap && ctl_r.action && ctl_r.irq_enable_bit;
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      wrap_r <= 1'b0;
    end else begin
      wrap_r <= wrap_nxt;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      rst_req_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      rst_req_r <= rst_req_nxt;
      irq_r <= irq_nxt;
    end
  end
  assign O_SYS_RST_REQ = rst_req_r;
  assign O_WDT_IRQ = irq_r;

  // ****************************************
  // Read data
  // ****************************************
  logic [31:0] st_word;
  logic [31:0] rd_mux;
  assign st_word = {26'h0, reload_pend_r, run_r, wrap_r, win_upd_r,
    rld_upd_r, ctl_upd_r};
  assign rd_mux = hit_ctl ? {26'h0, ctl_sh_r} :
    hit_rld ? {20'h0, rld_sh_r} :
    hit_st ? st_word :
    hit_win ? {20'h0, win_sh_r} :
    hit_cnt ? {20'h0, cnt_r} : 32'h0;
  logic rd_setup;
  logic [31:0] rdata_nxt;
  // Read data captured in the setup cycle
  assign rd_setup = setup_ph && !I_PWRITE;
  assign rdata_nxt = rd_setup ? rd_mux : rdata_r;
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      rdata_r <= 32'h0;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end
  assign O_PRDATA = rdata_r;
endmodule

// ### tb/wiwdt_bench.sv
`timescale 1ns/1ps
module wiwdt_bench;
  // ****************************************
  // Stimulus and checks
  // ****************************************
  logic clk, rst_b, psel, penable, pwrite, lso, sleep, err_seen;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, v, v2;
  logic lso_run;
  logic pready, pslverr, sys_rst, irq;
  int err_count = 0, num_checks = 0, cyc = 0, b, r;
  int rst_cnt = 0, irq_cnt = 0, t_prev = 0, t_last = 0;
  wiwdt_top #(.ADDR_W(8)) DUT (.I_CLK(clk), .I_RST_B(rst_b),
    .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite),
    .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
    .O_PREADY(pready), .O_PSLVERR(pslverr), .I_LSO_CLK(lso),
    .I_DEEP_SLEEP(sleep), .O_SYS_RST_REQ(sys_rst), .O_WDT_IRQ(irq));
  initial begin
    clk = 0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (lso_run && cyc % 4 == 3) lso <= ~lso;
    if (sys_rst === 1'b1) begin
      rst_cnt <= rst_cnt + 1;
      t_prev <= t_last;
      t_last <= cyc;
    end
    if (irq === 1'b1) irq_cnt <= irq_cnt + 1;
    if (cyc == 40000) begin
      err_count++;
      wrap_up;
    end
  end
  task wrap_up;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    num_checks++;
    if (s !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err_seen = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task key(input logic [15:0] k);
    apb(1, 8'h00, {16'h0000, k});
  endtask
  task wait_st(input logic [31:0] m);
    repeat (50) begin
      apb(0, 8'h0c, 0);
      if ((rd & m) === 0) break;
    end
    chk("flags_clear", 0, rd & m);
  endtask
  task rd_cnt;
    repeat (10) begin
      apb(0, 8'h24, 0); v2 = rd;
      apb(0, 8'h24, 0);
      if (rd === v2) break;
    end
  endtask
  task cfg(input logic [31:0] c, input logic [31:0] rl);
    key(16'h5555); apb(1, 8'h04, c); apb(1, 8'h08, rl);
    wait_st(32'h07);
    key(16'haaaa);
    wait_st(32'h20);
  endtask
  task t_reset;
    apb(0, 8'h0c, 0); chk("status", 0, rd);
    apb(0, 8'h10, 0); chk("window", 32'h0fff, rd);
    apb(0, 8'h08, 0); chk("reload", 32'h0fff, rd);
    apb(0, 8'h04, 0); chk("control", 0, rd);
    apb(0, 8'h30, 0); chk("slverr", 1, err_seen);
    key(16'h5555); apb(1, 8'h08, 5);
    apb(0, 8'h08, 0); chk("rld_stopped", 32'h0fff, rd);
  endtask
  task t_lock;
    key(16'hcccc); apb(0, 8'h0c, 0); chk("run", 32'h10, rd & 32'h10);
    apb(0, 8'h24, 0); chk("cnt_start", 8'hff, rd[11:4]);
    apb(1, 8'h08, 5); apb(0, 8'h08, 0); chk("locked", 32'h0fff, rd);
    key(16'h5555); key(16'h1234); apb(1, 8'h08, 5);
    apb(0, 8'h08, 0); chk("relock", 32'h0fff, rd);
    key(16'h5555); key(16'haaaa); apb(1, 8'h08, 5);
    apb(0, 8'h08, 0); chk("key_lock", 32'h0fff, rd);
    lso_run <= 0; repeat (6) @(posedge clk);
    key(16'h5555); apb(1, 8'h08, 5);
    apb(0, 8'h0c, 0); chk("rld_flag", 32'h2, rd & 32'h2);
    lso_run <= 1;
    wait_st(32'h07); apb(0, 8'h08, 0); chk("unlocked", 5, rd);
  endtask
  task t_period;
    for (int p = 0; p < 2; p++) begin
      cfg(p, 3);
      b = rst_cnt;
      repeat (2000) if (rst_cnt < b + 2) @(posedge clk);
      chk("period", 4 * (4 << p) * 8, t_last - t_prev);
      apb(0, 8'h0c, 0); chk("wrap_set", 32'h8, rd & 32'h8);
      apb(1, 8'h0c, 0); apb(0, 8'h0c, 0);
      chk("wrap_clr", 0, rd & 32'h8);
    end
  endtask
  task t_irq;
    for (int e = 1; e >= 0; e--) begin
      cfg(e ? 32'h18 : 32'h08, 3);
      b = irq_cnt; r = rst_cnt;
      repeat (300) @(posedge clk);
      chk("irq_cnt", e, (irq_cnt - b) >= 2);
      chk("no_reset", r, rst_cnt);
    end
  endtask
  task t_sleep;
    for (int p = 0; p < 2; p++) begin
      cfg(p ? 32'h28 : 32'h08, 200);
      sleep <= 1;
      repeat (8) @(posedge clk);
      rd_cnt; v = rd;
      repeat (100) @(posedge clk);
      rd_cnt; chk("sleep_hold", p, rd === v);
      sleep <= 0;
      repeat (100) @(posedge clk);
      rd_cnt; chk("resume", 1, rd !== v);
    end
  endtask
  task t_window;
    cfg(32'h08, 200);
    repeat (1000) @(posedge clk);
    key(16'h5555); apb(1, 8'h10, 100); wait_st(32'h07);
    apb(0, 8'h24, 0); chk("win_reload", 1, rd > 195);
    b = rst_cnt; key(16'haaaa); repeat (4) @(posedge clk);
    chk("early_rst", b + 1, rst_cnt);
    repeat (3500) @(posedge clk);
    b = rst_cnt; key(16'haaaa); repeat (4) @(posedge clk);
    chk("in_window", b, rst_cnt);
  endtask
  task t_stop;
    key(16'h5a5a); key(16'haaaa); key(16'ha5a5);
    apb(0, 8'h0c, 0); chk("not_stop", 32'h10, rd & 32'h10);
    key(16'h5a5a); key(16'ha5a5);
    apb(0, 8'h0c, 0); chk("stopped", 0, rd & 32'h10);
  endtask
  initial begin
    rst_b = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0;
    pwdata = 0; sleep = 0; lso = 0; lso_run = 1;
    repeat (12) @(posedge clk);
    rst_b <= 1;
    t_reset; t_lock; t_period; t_irq; t_sleep; t_window; t_stop;
    wrap_up;
  end
endmodule

// ### tb/wiwdt_props.sv
`timescale 1ns/1ps
module wiwdt_props #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_RST_B,
  // APB slave
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [ADDR_W-1:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  input wire logic [31:0] O_PRDATA,
  input wire logic O_PREADY,
  input wire logic O_PSLVERR,
  // Oscillator and sleep
  input wire logic I_LSO_CLK,
  input wire logic I_DEEP_SLEEP,
  // Actions
  input wire logic O_SYS_RST_REQ,
  input wire logic O_WDT_IRQ
);
  // ****************************************
  // Port checks
  // ****************************************
  logic rd_set;
  logic unmapped;
  assign rd_set = I_PSEL & ~I_PENABLE & ~I_PWRITE;
  assign unmapped = !(I_PADDR inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10,
                                      8'h24});
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RST_B);
  rst_pulse_a: assert property (O_SYS_RST_REQ |=> !O_SYS_RST_REQ)
    else $error("reset request longer than one cycle");
  irq_pulse_a: assert property (O_WDT_IRQ |=> !O_WDT_IRQ)
    else $error("interrupt longer than one cycle");
  action_excl_a: assert property (!(O_SYS_RST_REQ && O_WDT_IRQ))
    else $error("reset and interrupt together");
  status_bits_a: assert property (rd_set && I_PADDR == 8'h0c
    |=> O_PRDATA[31:6] == 26'h0) else $error("status upper bits set");
  count_bits_a: assert property (rd_set && I_PADDR == 8'h24
    |=> O_PRDATA[31:12] == 20'h0) else $error("counter wider than 12");
  window_bits_a: assert property (rd_set && I_PADDR == 8'h10
    |=> O_PRDATA[31:12] == 20'h0) else $error("window wider than 12");
  idle_quiet_a: assert property ($rose(I_RST_B)
    |-> !O_SYS_RST_REQ [*8]) else $error("reset request while stopped");
  slverr_dec_a: assert property (O_PREADY && O_PSLVERR ==
    (I_PSEL && I_PENABLE && unmapped)) else $error("bad error decode");
endmodule
bind wiwdt_top wiwdt_props #(.ADDR_W(ADDR_W)) u_props (
  .I_CLK(I_CLK), .I_RST_B(I_RST_B), .I_PSEL(I_PSEL),
  .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR),
  .I_PWDATA(I_PWDATA), .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY),
  .O_PSLVERR(O_PSLVERR), .I_LSO_CLK(I_LSO_CLK),
  .I_DEEP_SLEEP(I_DEEP_SLEEP), .O_SYS_RST_REQ(O_SYS_RST_REQ),
  .O_WDT_IRQ(O_WDT_IRQ));
